// ### pis_pkg.sv
// Shared constants, types and helpers for the interrupt source block
package pis_pkg;
  localparam int PIS_NUM_EP = 5;
  localparam int PIS_NUM_SRC = 8;
  localparam int PIS_NUM_HUB = 7;
  localparam int PIS_NUM_GPIO = 8;
  // Pending bit positions
  localparam int PIS_BIT_EP0 = 0;
  localparam int PIS_BIT_HUB = 5;
  localparam int PIS_BIT_GPIO = 6;
  localparam int PIS_BIT_I2C = 7;
  // Vector numbers, lower number wins
  localparam logic [3:0] PIS_VEC_EP0 = 4'h4;
  localparam logic [3:0] PIS_VEC_HUB = 4'h9;
  localparam logic [3:0] PIS_VEC_GPIO = 4'hB;
  localparam logic [3:0] PIS_VEC_I2C = 4'hC;
  localparam logic [3:0] PIS_VEC_NONE = 4'h0;
  localparam logic [7:0] PIS_PEND_RST = 8'h00;

  typedef enum logic [2:0] {
    PIS_I2C_IDLE, PIS_I2C_SRX, PIS_I2C_STX,
    PIS_I2C_MTX, PIS_I2C_MRX, PIS_I2C_ARBW
  } pis_i2c_st_t;

  // Firmware write to the two-wire status and control bits
  typedef struct packed {
    logic proceed;
    logic masterRoleSelect;
    logic xmit;
    logic ack;
  } pis_i2c_ctl_t;

  // Two-wire status as firmware reads it
  typedef struct packed {
    logic busy;
    logic masterRoleSelect;
    logic xmit;
    logic ack;
    logic addr;
    logic stopSeen;
    logic arbitrationLostFlag;
  } pis_i2c_stat_t;

  localparam pis_i2c_stat_t PIS_STAT_RST = 7'h00;

  function automatic logic [3:0] pis_bit_vec(input logic [2:0] idx);
    logic [3:0] v;
    v = PIS_VEC_NONE;
    if (idx < 3'(PIS_NUM_EP)) v = PIS_VEC_EP0 + 4'(idx);
    else if (idx == 3'(PIS_BIT_HUB)) v = PIS_VEC_HUB;
    else if (idx == 3'(PIS_BIT_GPIO)) v = PIS_VEC_GPIO;
    else v = PIS_VEC_I2C;
    return v;
  endfunction

  function automatic logic [7:0] pis_vec_bit(input logic [3:0] vec);
    logic [7:0] b;
    b = 8'h00;
    for (int i = 0; i < PIS_NUM_SRC; i++) begin
      if (pis_bit_vec(3'(i)) == vec) b[i] = 1'b1;
    end
    return b;
  endfunction
endpackage

// ### pis_pend.sv
// Pending flip-flops, one per interrupt source
`timescale 1ns/1ps
module pis_pend (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [7:0] setVec,
  input wire logic [7:0] clrVec,
  output logic [7:0] pend
);
  import pis_pkg::*;
  logic [7:0] pend_r;
  logic [7:0] pend_nxt;

  // A new event beats a service clear in the same cycle
  always_comb begin
    pend_nxt = (pend_r & ~clrVec) | setVec;
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pend_r <= PIS_PEND_RST;
    end else begin
      pend_r <= pend_nxt;
    end
  end

  assign pend = pend_r;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  chk_pend_hold: assert property (
    pend_r[PIS_BIT_I2C] && !clrVec[PIS_BIT_I2C] |=> pend_r[PIS_BIT_I2C])
    else $error("pending flag dropped without service");
endmodule

// ### pis_sources.sv
// Interrupt event sources: endpoints, hub, GPIO, two-wire controller
// How it works
// - One interrupt source per endpoint, five total
// - Endpoint interrupt only on final acknowledged packet
// - IN without host acknowledge raises nothing
// - Hub interrupt on connect change, babble, resume
// - Babble and resume gated by port enable
// - Forced port connect change raises nothing
// - Each enabled GPIO pin triggers, polarity selectable
// - All GPIO triggers share one request
// - Triggering pin locks others until released
// - No pin priority; enables kept on acknowledge
// - Two-wire interrupt only after status settles
// - Slave receive interrupts per byte, flags address
// - Stop seen flagged, skipped after refused byte
// - Slave transmit interrupts, shows master acknowledge
// - Master transmit; role cleared issues stop, idle
// - Master receive; role cleared issues stop, idle
// - Lost arbitration: clear role, flag, wait stop
// - Busy cleared before byte and stop interrupts, except master receive bytes and the stop after lost arbitration
// - Controller may be busy during transfer
// - Each source latches pending until serviced
// - Lowest vector number wins priority
`timescale 1ns/1ps
module pis_sources (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic usbTxnEnd,
  input wire logic [2:0] usbTxnEp,
  input wire logic usbTxnIn,
  input wire logic usbHostAck,
  input wire logic usbDevAck,
  input wire logic [6:0] hubConnChg,
  input wire logic [6:0] hubForced,
  input wire logic [6:0] hubBabble,
  input wire logic [6:0] hubResume,
  input wire logic [6:0] hubPortEn,
  input wire logic [7:0] gpioPins,
  input wire logic [7:0] gpioIntEn,
  input wire logic gpioPolHigh,
  input wire logic i2cStart,
  input wire logic i2cStop,
  input wire logic i2cByte,
  input wire logic i2cBusAck,
  input wire logic i2cArbLost,
  input wire logic fwWr,
  input wire pis_pkg::pis_i2c_ctl_t fwCtl,
  input wire logic [7:0] intEn,
  input wire logic svcAck,
  input wire logic [3:0] svcVec,
  output pis_pkg::pis_i2c_stat_t i2cStat,
  output logic i2cIssueStop,
  output logic [7:0] pending,
  output logic irqReq,
  output logic [3:0] irqVec
);
  import pis_pkg::*;

  // Endpoint and hub event pulses
  logic [4:0] epSet_r;
  logic [4:0] epSet_nxt;
  logic hubSet_r;
  logic hubSet_nxt;
  logic epFinal;

  always_comb begin
    epFinal = usbTxnEnd && (usbTxnIn ? usbHostAck : usbDevAck);
    epSet_nxt = 5'h00;
    if (epFinal && usbTxnEp < 3'(PIS_NUM_EP)) begin
      epSet_nxt[usbTxnEp] = 1'b1;
    end
    hubSet_nxt = |(hubConnChg & ~hubForced)
      || |((hubBabble | hubResume) & hubPortEn);
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      epSet_r <= 5'h00;
      hubSet_r <= 1'b0;
    end else begin
      epSet_r <= epSet_nxt;
      hubSet_r <= hubSet_nxt;
    end
  end

  // GPIO trigger with lock on the first triggering pin
  logic [7:0] gpioTrig;
  logic gpioLock_r;
  logic gpioLock_nxt;
  logic [2:0] gpioIdx_r;
  logic [2:0] gpioIdx_nxt;
  logic gpioSet_r;
  logic gpioSet_nxt;

  always_comb begin
    gpioTrig = gpioIntEn & (gpioPolHigh ? gpioPins : ~gpioPins);
    gpioLock_nxt = gpioLock_r;
    gpioIdx_nxt = gpioIdx_r;
    gpioSet_nxt = 1'b0;
    if (gpioLock_r) begin
      if (!gpioTrig[gpioIdx_r]) gpioLock_nxt = 1'b0;
    end else if (|gpioTrig) begin
      gpioLock_nxt = 1'b1;
      gpioSet_nxt = 1'b1;
      for (int i = PIS_NUM_GPIO - 1; i >= 0; i--) begin
        if (gpioTrig[i]) gpioIdx_nxt = 3'(i);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      gpioLock_r <= 1'b0;
      gpioIdx_r <= 3'h0;
      gpioSet_r <= 1'b0;
    end else begin
      gpioLock_r <= gpioLock_nxt;
      gpioIdx_r <= gpioIdx_nxt;
      gpioSet_r <= gpioSet_nxt;
    end
  end

  // Two-wire controller handshake
  pis_i2c_st_t st_r;
  pis_i2c_st_t st_nxt;
  pis_i2c_stat_t stat_r;
  pis_i2c_stat_t stat_nxt;
  logic first_r;
  logic first_nxt;
  logic ackOff_r;
  logic ackOff_nxt;
  logic i2cEvt_r;
  logic i2cEvt_nxt;
  logic stop_r;
  logic stop_nxt;
  logic inMaster;

  always_comb begin
    st_nxt = st_r;
    stat_nxt = stat_r;
    first_nxt = first_r;
    ackOff_nxt = ackOff_r;
    i2cEvt_nxt = 1'b0;
    stop_nxt = 1'b0;
    inMaster = (st_r == PIS_I2C_MTX) || (st_r == PIS_I2C_MRX);
    if (fwWr) begin
      stat_nxt.busy = fwCtl.proceed;
      stat_nxt.masterRoleSelect = fwCtl.masterRoleSelect;
      stat_nxt.xmit = fwCtl.xmit;
      stat_nxt.ack = fwCtl.ack;
      stat_nxt.addr = 1'b0;
      stat_nxt.stopSeen = 1'b0;
      stat_nxt.arbitrationLostFlag = 1'b0;
      if (fwCtl.proceed) begin
        unique case (st_r)
          PIS_I2C_IDLE: begin
            if (fwCtl.masterRoleSelect) begin
              st_nxt = fwCtl.xmit ? PIS_I2C_MTX : PIS_I2C_MRX;
            end
          end
          PIS_I2C_SRX, PIS_I2C_STX: begin
            st_nxt = fwCtl.xmit ? PIS_I2C_STX : PIS_I2C_SRX;
          end
          PIS_I2C_MTX, PIS_I2C_MRX: begin
            if (!fwCtl.masterRoleSelect) begin
              stop_nxt = 1'b1;
              st_nxt = PIS_I2C_IDLE;
              stat_nxt.busy = 1'b0;
            end else begin
              st_nxt = fwCtl.xmit ? PIS_I2C_MTX : PIS_I2C_MRX;
            end
          end
          PIS_I2C_ARBW: begin
          end
        endcase
      end
    end
    // Hardware events come after the write so that they win
    if (i2cArbLost && inMaster) begin
      stat_nxt.masterRoleSelect = 1'b0;
      stat_nxt.arbitrationLostFlag = 1'b1;
      st_nxt = PIS_I2C_ARBW;
    end else if (i2cByte) begin
      unique case (st_r)
        PIS_I2C_SRX: begin
          stat_nxt.addr = first_r;
          first_nxt = 1'b0;
          ackOff_nxt = !stat_r.ack;
          stat_nxt.busy = 1'b0;
          i2cEvt_nxt = 1'b1;
        end
        PIS_I2C_STX: begin
          stat_nxt.ack = i2cBusAck;
          stat_nxt.busy = 1'b0;
          i2cEvt_nxt = 1'b1;
        end
        PIS_I2C_MTX: begin
          stat_nxt.busy = 1'b0;
          i2cEvt_nxt = 1'b1;
        end
        PIS_I2C_MRX: begin
          i2cEvt_nxt = 1'b1;
        end
        PIS_I2C_IDLE, PIS_I2C_ARBW: begin
        end
      endcase
    end else if (i2cStop) begin
      unique case (st_r)
        PIS_I2C_SRX: begin
          if (!ackOff_r) begin
            stat_nxt.stopSeen = 1'b1;
            stat_nxt.busy = 1'b0;
            i2cEvt_nxt = 1'b1;
          end
          st_nxt = PIS_I2C_IDLE;
        end
        PIS_I2C_ARBW: begin
          i2cEvt_nxt = 1'b1;
          st_nxt = PIS_I2C_IDLE;
        end
        PIS_I2C_STX: st_nxt = PIS_I2C_IDLE;
        PIS_I2C_IDLE, PIS_I2C_MTX, PIS_I2C_MRX: begin
        end
      endcase
    end else if (i2cStart && !inMaster && st_r != PIS_I2C_ARBW) begin
      first_nxt = 1'b1;
      ackOff_nxt = 1'b0;
      if (st_r == PIS_I2C_IDLE) st_nxt = PIS_I2C_SRX;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= PIS_I2C_IDLE;
      stat_r <= PIS_STAT_RST;
      first_r <= 1'b0;
      ackOff_r <= 1'b0;
      i2cEvt_r <= 1'b0;
      stop_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      stat_r <= stat_nxt;
      first_r <= first_nxt;
      ackOff_r <= ackOff_nxt;
      i2cEvt_r <= i2cEvt_nxt;
      stop_r <= stop_nxt;
    end
  end

  // Pending flags and priority request
  logic [7:0] pendSet;
  logic [7:0] pendClr;
  logic [7:0] pendQ;
  logic irqReq_r;
  logic irqReq_nxt;
  logic [3:0] irqVec_r;
  logic [3:0] irqVec_nxt;
  logic [7:0] active;

  always_comb begin
    pendSet = {i2cEvt_r, gpioSet_r, hubSet_r, epSet_r};
    pendClr = svcAck ? pis_vec_bit(svcVec) : 8'h00;
    active = pendQ & intEn;
    irqReq_nxt = |active;
    irqVec_nxt = PIS_VEC_NONE;
    for (int i = PIS_NUM_SRC - 1; i >= 0; i--) begin
      if (active[i]) irqVec_nxt = pis_bit_vec(3'(i));
    end
  end

  pis_pend uPend (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .setVec(pendSet),
    .clrVec(pendClr),
    .pend(pendQ)
  );

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      irqReq_r <= 1'b0;
      irqVec_r <= PIS_VEC_NONE;
    end else begin
      irqReq_r <= irqReq_nxt;
      irqVec_r <= irqVec_nxt;
    end
  end

  assign i2cStat = stat_r;
  assign i2cIssueStop = stop_r;
  assign pending = pendQ;
  assign irqReq = irqReq_r;
  assign irqVec = irqVec_r;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence srxByteSeq;
    st_r == PIS_I2C_SRX && i2cByte && !i2cArbLost;
  endsequence
  sequence busyThenPend;
    !stat_r.busy && i2cEvt_r ##1 pendQ[PIS_BIT_I2C];
  endsequence

  chk_ep_noack: assert property (
    usbTxnEnd && usbTxnIn && !usbHostAck |=> epSet_r == 5'h00)
    else $error("endpoint event raised without host acknowledge");
  chk_ep_final: assert property (
    epFinal && usbTxnEp == 3'h2 |=> epSet_r == 5'h04 ##1 pendQ[2])
    else $error("endpoint final packet not latched");
  chk_hub_forced: assert property (
    hubConnChg == hubForced && (hubBabble | hubResume) == 7'h00
    |=> !hubSet_r)
    else $error("forced port raised hub event");
  chk_hub_gate: assert property (
    hubConnChg == 7'h00 && ((hubBabble | hubResume) & hubPortEn) == 7'h00
    |=> !hubSet_r)
    else $error("disabled port babble or resume raised hub event");
  chk_gpio_lock: assert property (
    gpioLock_r && gpioTrig[gpioIdx_r] |=> !gpioSet_r)
    else $error("second GPIO trigger while locked");
  chk_busy_clear: assert property (
    srxByteSeq |=> busyThenPend)
    else $error("busy not cleared before slave byte interrupt");
  chk_arb_lost: assert property (
    i2cArbLost && inMaster |=> !stat_r.masterRoleSelect
    && stat_r.arbitrationLostFlag && !i2cEvt_r)
    else $error("arbitration loss handled wrongly");
  chk_master_stop: assert property (
    fwWr && fwCtl.proceed && !fwCtl.masterRoleSelect && inMaster
    && !i2cArbLost |=> i2cIssueStop && st_r == PIS_I2C_IDLE ##1 !i2cIssueStop)
    else $error("master stop not issued for one cycle");
  chk_prio_vec: assert property (
    pendQ[PIS_BIT_HUB] && intEn[PIS_BIT_HUB] && !(|(pendQ[4:0] & intEn[4:0]))
    |=> irqReq_r && irqVec_r == PIS_VEC_HUB)
    else $error("hub request not given priority");
endmodule

// ### pis_core_model.sv
// Core model that services the lowest pending vector
`timescale 1ns/1ps
module pis_core_model (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic irqReq,
  input wire logic [3:0] irqVec,
  input wire logic [2:0] lateness,
  output logic svcAck,
  output logic [3:0] svcVec
);
  logic [3:0] holdCnt_r;
  // Gap after each service lets pending and request settle again
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      svcAck <= 1'h0;
      svcVec <= 4'h0;
      holdCnt_r <= 4'h0;
    end else if (svcAck) begin
      svcAck <= 1'h0;
      holdCnt_r <= 4'h4 + 4'(lateness);
    end else if (holdCnt_r != 4'h0) begin
      holdCnt_r <= holdCnt_r - 4'h1;
    end else if (irqReq) begin
      svcAck <= 1'h1;
      svcVec <= irqVec;
    end
  end
endmodule

// ### tb_top.sv
// Self-checking bench for the interrupt source block
`timescale 1ns/1ps
module tb_top;
  import pis_pkg::*;
  logic ref_clk = 1'h0;
  logic nrst = 1'h0;
  logic usbTxnEnd = 1'h0, usbTxnIn = 1'h0, usbHostAck = 1'h0;
  logic usbDevAck = 1'h0, gpioPolHigh = 1'h1, i2cStart = 1'h0;
  logic i2cStop = 1'h0, i2cByte = 1'h0, i2cBusAck = 1'h0;
  logic i2cArbLost = 1'h0, fwWr = 1'h0, svcAck, i2cIssueStop, irqReq;
  logic [2:0] usbTxnEp = 3'h0, lateness = 3'h0;
  logic [6:0] hubConnChg = 7'h00, hubForced = 7'h00, hubBabble = 7'h00;
  logic [6:0] hubResume = 7'h00, hubPortEn = 7'h7F;
  logic [7:0] gpioPins = 8'h00, gpioIntEn = 8'h00, intEn = 8'hFF;
  logic [7:0] pending;
  logic [3:0] svcVec, irqVec;
  pis_i2c_ctl_t fwCtl = 4'h0;
  pis_i2c_stat_t i2cStat;
  logic [3:0] expQ[$];
  int errors = 0;
  int checkCount = 0;
  int p, a, b;

  pis_sources u_dut (.ref_clk, .nrst, .usbTxnEnd, .usbTxnEp, .usbTxnIn,
    .usbHostAck, .usbDevAck, .hubConnChg, .hubForced, .hubBabble,
    .hubResume, .hubPortEn, .gpioPins, .gpioIntEn, .gpioPolHigh,
    .i2cStart, .i2cStop, .i2cByte, .i2cBusAck, .i2cArbLost, .fwWr,
    .fwCtl, .intEn, .svcAck, .svcVec, .i2cStat, .i2cIssueStop, .pending,
    .irqReq, .irqVec);
  pis_core_model u_core (.ref_clk, .nrst, .irqReq, .irqVec, .lateness,
    .svcAck, .svcVec);

  initial begin
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checkCount++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    if (errors == 0 && checkCount > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic pls(ref logic s);
    s = 1'h1;
    step(1);
    s = 1'h0;
  endtask

  task automatic fw(input logic [3:0] c);
    fwCtl = c;
    fwWr = 1'h1;
    step(1);
    fwWr = 1'h0;
  endtask

  // Every noted vector must have been serviced by now
  task automatic settle();
    step(30);
    chk(8'(expQ.size()), 8'h00);
  endtask

  // Each service taken by the core is matched to the oldest note
  always @(posedge ref_clk) begin
    if (nrst === 1'h1 && svcAck === 1'h1) begin
      if (expQ.size() == 0) chk({4'h0, svcVec}, 8'hFF);
      else chk({4'h0, svcVec}, {4'h0, expQ.pop_front()});
    end
  end

  initial begin
    #(100 * 9000);
    errors++;
    print_verdict();
  end

  initial begin
    p = $urandom(32'hF89A7995);
    step(8);
    nrst = 1'h1;
    step(2);
    for (int e = 0; e < 6; e++) begin
      lateness = 3'($urandom % 8);
      usbTxnIn = 1'($urandom % 2);
      usbTxnEp = 3'(e);
      usbHostAck = usbTxnIn;
      usbDevAck = !usbTxnIn;
      if (e < PIS_NUM_EP) expQ.push_back(PIS_VEC_EP0 + 4'(e));
      pls(usbTxnEnd);
      usbHostAck = !usbHostAck;
      usbDevAck = !usbDevAck;
      step(1);
      pls(usbTxnEnd);
      settle();
    end
    for (int k = 0; k < 6; k++) begin
      p = $urandom % 7;
      hubForced = (k == 1) ? 7'h01 << p : 7'h00;
      hubPortEn = (k > 3) ? ~(7'h01 << p) : 7'h7F;
      if (k != 1 && k < 4) expQ.push_back(PIS_VEC_HUB);
      hubConnChg[p] = 1'(k < 2);
      hubBabble[p] = 1'(k == 2 || k == 4);
      hubResume[p] = 1'(k == 3 || k == 5);
      step(1);
      {hubConnChg, hubBabble, hubResume} = 21'h0;
      settle();
    end
    a = $urandom % 4;
    b = a + 4;
    gpioIntEn = 8'hFF;
    expQ.push_back(PIS_VEC_GPIO);
    gpioPins[a] = 1'h1;
    settle();
    gpioPins[b] = 1'h1;
    settle();
    gpioPins[b] = 1'h0;
    step(2);
    gpioPins[a] = 1'h0;
    step(2);
    expQ.push_back(PIS_VEC_GPIO);
    gpioPins[b] = 1'h1;
    settle();
    gpioIntEn[b] = 1'h0;
    step(2);
    expQ.push_back(PIS_VEC_GPIO);
    gpioPins[a] = 1'h1;
    settle();
    gpioIntEn = 8'h00;
    gpioPins = 8'hFF;
    gpioPolHigh = 1'h0;
    step(2);
    gpioIntEn = 8'hFF;
    step(2);
    expQ.push_back(PIS_VEC_GPIO);
    gpioPins[b] = 1'h0;
    settle();
    gpioIntEn = 8'h00;
    gpioPins = 8'h00;
    gpioPolHigh = 1'h1;
    intEn = 8'h00;
    usbTxnEp = 3'h4;
    usbTxnIn = 1'h0;
    usbDevAck = 1'h1;
    hubConnChg = 7'h01;
    pls(usbTxnEnd);
    hubConnChg = 7'h00;
    step(5);
    chk(pending, 8'h30);
    expQ.push_back(PIS_VEC_EP0 + 4'h4);
    expQ.push_back(PIS_VEC_HUB);
    intEn = 8'hFF;
    settle();
    for (int x = 1; x >= 0; x--) begin
      fw({2'h3, 1'(x), 1'h1});
      expQ.push_back(PIS_VEC_I2C);
      pls(i2cByte);
      settle();
      chk(8'(i2cStat.busy), 8'(1 - x));
      fw(4'h8);
      p = 0;
      repeat (4) begin
        if (i2cIssueStop === 1'h1) p++;
        step(1);
      end
      chk(8'(p), 8'h01);
      chk(8'(i2cStat.masterRoleSelect), 8'h00);
    end
    fw(4'hE);
    pls(i2cArbLost);
    step(2);
    chk(8'(i2cStat.masterRoleSelect), 8'h00);
    chk(8'(i2cStat.arbitrationLostFlag), 8'h01);
    settle();
    expQ.push_back(PIS_VEC_I2C);
    pls(i2cStop);
    settle();
    pls(i2cStart);
    expQ.push_back(PIS_VEC_I2C);
    pls(i2cByte);
    settle();
    chk(8'(i2cStat.addr), 8'h01);
    for (int k = 1; k >= 0; k--) begin
      i2cBusAck = 1'(k);
      fw(4'hB);
      expQ.push_back(PIS_VEC_I2C);
      pls(i2cByte);
      settle();
      chk(8'(i2cStat.ack), 8'(k));
      chk(8'(i2cStat.xmit), 8'h01);
      chk(8'(i2cStat.busy), 8'h00);
    end
    pls(i2cStop);
    settle();
    for (int k = 1; k >= 0; k--) begin
      pls(i2cStart);
      expQ.push_back(PIS_VEC_I2C);
      pls(i2cByte);
      settle();
      fw({3'h4, 1'(k)});
      expQ.push_back(PIS_VEC_I2C);
      pls(i2cByte);
      settle();
      chk(8'(i2cStat.addr), 8'h00);
      if (k == 1) expQ.push_back(PIS_VEC_I2C);
      pls(i2cStop);
      settle();
      chk(8'(i2cStat.stopSeen), 8'(k));
    end
    gpioIntEn = 8'hFF;
    expQ.push_back(PIS_VEC_GPIO);
    gpioPins[a] = 1'h1;
    settle();
    fw(4'hE);
    pls(i2cArbLost);
    nrst = 1'h0;
    step(2);
    chk({1'h0, i2cStat}, 8'h00);
    chk(pending, 8'h00);
    // Lock and arbitration wait must both be gone after reset
    expQ.push_back(PIS_VEC_GPIO);
    nrst = 1'h1;
    step(2);
    fw(4'hE);
    expQ.push_back(PIS_VEC_I2C);
    pls(i2cByte);
    settle();
    print_verdict();
  end
endmodule
